/* inc/pit_params.svh */
// Overview of operation
// - Level field 000 disables the timer interrupt.
// - Request bit 3 sets on underflow, clears on 0.
// - Start bit 0 cleared stops the count.
// - Bit 1 shows counter actually running.
// - Forced stop bit 2 halts count at once.
// - Forced stop bit always reads as 0.
// - Edge flag bit 4, cleared by writing 0.
// - Underflow flag bit 5, cleared by writing 0.
// - Mode field 000 selects plain timer mode.
// - Source field 001 selects clock divided eight.
// - Gate bit 7 at 0 passes source.
// - Main counter steps on each prescaler underflow.
// - Start 1 begins counting; software awaits status.
`ifndef PIT_PARAMS_SVH
`define PIT_PARAMS_SVH
`define PIT_ADDR_W 5
`define PIT_OFS_CTRL 5'h00
`define PIT_OFS_MODE 5'h04
`define PIT_OFS_IRQ 5'h08
`define PIT_OFS_PRE 5'h0C
`define PIT_OFS_CNT 5'h10
`define PIT_CT_START 0
`define PIT_CT_RUN 1
`define PIT_CT_STOP 2
`define PIT_CT_EDGE 4
`define PIT_CT_UNDF 5
`define PIT_MD_MODE_HI 2
`define PIT_MD_MODE_LO 0
`define PIT_MD_SRC_HI 6
`define PIT_MD_SRC_LO 4
`define PIT_MD_GATE 7
`define PIT_IC_LVL_HI 2
`define PIT_IC_LVL_LO 0
`define PIT_IC_REQ 3
`define PIT_MODE_TIMER 3'h0
`define PIT_SRC_DIV8 3'h1
`define PIT_LVL_OFF 3'h0
`define PIT_RST_BYTE 8'h00
`define PIT_RST_RELOAD 8'hFF
`define PIT_DIV_RATIO 8
`define PIT_DIV_LAST 3'h7
`endif

/* inc/pit_pkg.sv */
package pit_pkg;
    typedef struct packed {
        logic [4:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } pit_avreq_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } pit_avrsp_s;

    typedef enum logic [1:0] {
        PIT_BUS_IDLE = 2'b01,
        PIT_BUS_ACK = 2'b10
    } pit_bus_e;

    typedef logic [7:0] pit_byte_t;
endpackage : pit_pkg

/* rtl/pit_src_div.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pit_params.svh"
module pit_src_div (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [2:0] src_sel,
    input wire logic gate_off,
    output logic src_tick
);
    import pit_pkg::*;

    logic [2:0] div_cnt;

    // The divider runs freely so the phase of the source does not depend on
    // when software starts the timer.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            div_cnt <= 3'h0;
        end else begin
            div_cnt <= div_cnt + 3'h1;
        end
    end

    // Only the divide-by-eight source exists; other codes deliver no ticks.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            src_tick <= 1'b0;
        end else begin
            src_tick <= (src_sel == `PIT_SRC_DIV8) && !gate_off && (div_cnt == `PIT_DIV_LAST);
        end
    end
endmodule : pit_src_div
`default_nettype wire

/* rtl/pit_timer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pit_params.svh"
module pit_timer (
    input wire logic clk,
    input wire logic rst_b,
    input wire pit_pkg::pit_avreq_s av_req,
    output pit_pkg::pit_avrsp_s av_rsp,
    input wire logic edge_pin,
    output logic irq,
    output logic running,
    output logic underflow_pulse
);
    import pit_pkg::*;

    pit_bus_e bus_state;
    pit_bus_e next_bus_state;
    logic [31:0] rd_data;
    logic wait_req;
    logic wr_accept;
    logic [7:0] wr_byte;
    logic [31:0] next_rd_data;
    logic wr_ctrl;
    logic wr_mode;
    logic wr_irq;
    logic wr_pre;
    logic wr_cnt;

    logic start_bit;
    logic run_flag;
    logic edge_flag;
    logic undf_flag;
    logic [2:0] mode_sel;
    logic [2:0] src_sel;
    logic gate_off;
    logic [2:0] irq_level;
    logic irq_req;
    pit_byte_t pre_reload;
    pit_byte_t cnt_reload;
    pit_byte_t pre_count;
    pit_byte_t cnt_count;
    logic irq_out;
    logic undf_out;

    logic src_tick;
    logic count_tick;
    logic pre_undf;
    logic main_undf;
    logic force_stop;
    logic edge_rise;

    logic edge_s1;
    logic edge_s2;
    logic edge_s3;
    logic edge_level;

    assign av_rsp.readdata = rd_data;
    assign av_rsp.waitrequest = wait_req;
    assign irq = irq_out;
    assign running = run_flag;
    assign underflow_pulse = undf_out;

    function automatic logic wr_hit(
        input logic [`PIT_ADDR_W-1:0] ofs,
        input logic accept,
        input logic [`PIT_ADDR_W-1:0] addr,
        input logic [3:0] be
    );
        wr_hit = accept && (addr == ofs) && be[0];
    endfunction : wr_hit

    function automatic logic flag_next(
        input logic cur,
        input logic set,
        input logic clr
    );
        // A hardware event in the clearing cycle must not be lost.
        flag_next = set ? 1'b1 : (clr ? 1'b0 : cur);
    endfunction : flag_next

    function automatic logic at_zero(
        input pit_byte_t value
    );
        at_zero = (value == 8'h00);
    endfunction : at_zero

    // Bus handshake: one wait cycle, then the request is answered.
    always_comb begin
        next_bus_state = bus_state;
        case (bus_state)
            PIT_BUS_IDLE: begin
                if (av_req.read || av_req.write) begin
                    next_bus_state = PIT_BUS_ACK;
                end
            end
            PIT_BUS_ACK: begin
                next_bus_state = PIT_BUS_IDLE;
            end
            default: begin
                next_bus_state = PIT_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bus_state <= PIT_BUS_IDLE;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wait_req <= 1'b1;
        end else begin
            wait_req <= !(next_bus_state == PIT_BUS_ACK);
        end
    end

    // A write takes effect at the edge where waitrequest is seen low.
    assign wr_accept = av_req.write && (bus_state == PIT_BUS_ACK);
    assign wr_byte = av_req.writedata[7:0];

    // Each register's write strobe is decoded once, so every field of one
    // register sees exactly the same accept condition.
    assign wr_ctrl = wr_hit(`PIT_OFS_CTRL, wr_accept, av_req.address, av_req.byteenable);
    assign wr_mode = wr_hit(`PIT_OFS_MODE, wr_accept, av_req.address, av_req.byteenable);
    assign wr_irq = wr_hit(`PIT_OFS_IRQ, wr_accept, av_req.address, av_req.byteenable);
    assign wr_pre = wr_hit(`PIT_OFS_PRE, wr_accept, av_req.address, av_req.byteenable);
    assign wr_cnt = wr_hit(`PIT_OFS_CNT, wr_accept, av_req.address, av_req.byteenable);

    // The read word is picked while the bus is idle and held in a register, so
    // readdata stands unchanged through the cycle in which waitrequest is low.
    always_comb begin
        next_rd_data = rd_data;
        if (bus_state == PIT_BUS_IDLE && av_req.read) begin
            case (av_req.address)
                `PIT_OFS_CTRL: begin
                    next_rd_data = {26'h0, undf_flag, edge_flag, 1'b0, 1'b0, run_flag, start_bit};
                end
                `PIT_OFS_MODE: begin
                    next_rd_data = {24'h00_0000, gate_off, src_sel, 1'b0, mode_sel};
                end
                `PIT_OFS_IRQ: begin
                    next_rd_data = {28'h000_0000, irq_req, irq_level};
                end
                `PIT_OFS_PRE: begin
                    next_rd_data = {24'h00_0000, pre_count};
                end
                `PIT_OFS_CNT: begin
                    next_rd_data = {24'h00_0000, cnt_count};
                end
                default: begin
                    next_rd_data = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_data <= 32'h0000_0000;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    // Forced stop is a strobe; the bit itself is never stored.
    assign force_stop = wr_ctrl && wr_byte[`PIT_CT_STOP];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            start_bit <= 1'b0;
        end else if (force_stop) begin
            start_bit <= 1'b0;
        end else if (wr_ctrl) begin
            start_bit <= wr_byte[`PIT_CT_START];
        end
    end

    // The status follows the start bit one cycle later, so software sees
    // the counter's real state rather than its own request.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            run_flag <= 1'b0;
        end else if (force_stop) begin
            run_flag <= 1'b0;
        end else begin
            run_flag <= start_bit && (mode_sel == `PIT_MODE_TIMER);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode_sel <= `PIT_MODE_TIMER;
            src_sel <= 3'h0;
            gate_off <= 1'b0;
        end else if (wr_mode) begin
            mode_sel <= wr_byte[`PIT_MD_MODE_HI:`PIT_MD_MODE_LO];
            src_sel <= wr_byte[`PIT_MD_SRC_HI:`PIT_MD_SRC_LO];
            gate_off <= wr_byte[`PIT_MD_GATE];
        end
    end

    pit_src_div u_src_div (
        .clk(clk),
        .rst_b(rst_b),
        .src_sel(src_sel),
        .gate_off(gate_off),
        .src_tick(src_tick)
    );

    // Counting needs both the request and the confirmed status, so clearing the
    // start bit or a forced stop takes hold before the next source tick.
    assign count_tick = run_flag && start_bit && src_tick;
    assign pre_undf = count_tick && at_zero(pre_count);
    assign main_undf = pre_undf && at_zero(cnt_count);

    // Writes while stopped load the count too; while running only the
    // reload value changes, so the current period is not disturbed.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pre_reload <= `PIT_RST_RELOAD;
        end else if (wr_pre) begin
            pre_reload <= wr_byte;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_reload <= `PIT_RST_RELOAD;
        end else if (wr_cnt) begin
            cnt_reload <= wr_byte;
        end
    end

    // A forced stop reloads both stages, so a restart always begins a full period.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pre_count <= `PIT_RST_RELOAD;
        end else if (wr_pre && !run_flag) begin
            pre_count <= wr_byte;
        end else if (force_stop) begin
            pre_count <= pre_reload;
        end else if (pre_undf) begin
            pre_count <= pre_reload;
        end else if (count_tick) begin
            pre_count <= pre_count - 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_count <= `PIT_RST_RELOAD;
        end else if (wr_cnt && !run_flag) begin
            cnt_count <= wr_byte;
        end else if (force_stop) begin
            cnt_count <= cnt_reload;
        end else if (main_undf) begin
            cnt_count <= cnt_reload;
        end else if (pre_undf) begin
            cnt_count <= cnt_count - 8'h01;
        end
    end

    // Software may only clear the flags; writing 1 leaves them as they are.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            undf_flag <= 1'b0;
        end else begin
            undf_flag <= flag_next(undf_flag, main_undf,
                wr_ctrl && !wr_byte[`PIT_CT_UNDF]);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            edge_flag <= 1'b0;
        end else begin
            edge_flag <= flag_next(edge_flag, edge_rise,
                wr_ctrl && !wr_byte[`PIT_CT_EDGE]);
        end
    end

    // The edge pin is asynchronous; a level change counts only when the
    // second and third stages agree, which also filters single-cycle glitches.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            edge_s1 <= 1'b0;
            edge_s2 <= 1'b0;
            edge_s3 <= 1'b0;
        end else begin
            edge_s1 <= edge_pin;
            edge_s2 <= edge_s1;
            edge_s3 <= edge_s2;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            edge_level <= 1'b0;
        end else if (edge_s2 == edge_s3) begin
            edge_level <= edge_s3;
        end
    end

    assign edge_rise = (edge_s2 == edge_s3) && edge_s3 && !edge_level;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_level <= `PIT_LVL_OFF;
        end else if (wr_irq) begin
            irq_level <= wr_byte[`PIT_IC_LVL_HI:`PIT_IC_LVL_LO];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= flag_next(irq_req, main_undf,
                wr_irq && !wr_byte[`PIT_IC_REQ]);
        end
    end

    // The request bit latches even at level zero so software can poll it;
    // only the line to the interrupt controller is withheld.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= (irq_level != `PIT_LVL_OFF) && flag_next(irq_req, main_undf, 1'b0);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            undf_out <= 1'b0;
        end else begin
            undf_out <= main_undf;
        end
    end
endmodule : pit_timer
`default_nettype wire

/* bench/pit_timer_sva.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pit_params.svh"
module pit_timer_chk
    import pit_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire pit_pkg::pit_avreq_s av_req,
    input wire pit_pkg::pit_avrsp_s av_rsp,
    input wire logic edge_pin,
    input wire logic irq,
    input wire logic running,
    input wire logic underflow_pulse
);
    logic acc;
    logic lvl_nz;
    assign acc = av_req.write && !av_rsp.waitrequest && av_req.byteenable[0];
    // The level field is not visible at the ports, so it is shadowed from accepted writes.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lvl_nz <= 1'b0;
        end else if (acc && av_req.address == `PIT_OFS_IRQ) begin
            lvl_nz <= |av_req.writedata[2:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence ctrl_wr;
        acc && av_req.address == `PIT_OFS_CTRL;
    endsequence
    sequence ctrl_rd;
        av_req.read && !av_rsp.waitrequest && av_req.address == `PIT_OFS_CTRL;
    endsequence
    wait_one_a: assert property ($fell(av_rsp.waitrequest) |=> av_rsp.waitrequest)
        else $error("waitrequest low for more than one cycle");
    bus_ans_a: assert property ($rose(av_req.read || av_req.write) |-> ##[1:2] !av_rsp.waitrequest)
        else $error("bus request not answered in time");
    read_hi_a: assert property ((av_req.read && !av_rsp.waitrequest) |-> av_rsp.readdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    irq_lvl_a: assert property (irq |-> lvl_nz || $past(lvl_nz))
        else $error("irq high with level zero");
    stop_start_a: assert property ((ctrl_wr ##0 !av_req.writedata[0]) |-> ##3 !running)
        else $error("running stays after start cleared");
    stop_force_a: assert property ((ctrl_wr ##0 av_req.writedata[2]) |-> ##2 !running)
        else $error("running stays after forced stop");
    stop_read_a: assert property (ctrl_rd |-> !av_rsp.readdata[2])
        else $error("forced stop bit reads one");
    undf_once_a: assert property (underflow_pulse |=> !underflow_pulse)
        else $error("underflow pulse longer than one cycle");
    undf_irq_a: assert property ((underflow_pulse && lvl_nz) |-> ##[0:2] irq)
        else $error("underflow did not raise irq");
endmodule : pit_timer_chk
bind pit_timer pit_timer_chk pit_timer_chk_inst (.clk(clk), .rst_b(rst_b), .av_req(av_req), .av_rsp(av_rsp),
    .edge_pin(edge_pin), .irq(irq), .running(running), .underflow_pulse(underflow_pulse));
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pit_params.svh"
module tb_top;
    import pit_pkg::*;
    localparam int PERIOD = `PIT_DIV_RATIO * 2 * 2;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    pit_avreq_s av_req = '0;
    pit_avrsp_s av_rsp;
    logic edge_pin = 1'b0;
    logic irq;
    logic running;
    logic underflow_pulse;
    int errors = 0;
    int tests_run = 0;
    pit_byte_t rd;
    int c;
    always #10 clk = ~clk;
    pit_timer pit_timer_inst (.clk(clk), .rst_b(rst_b), .av_req(av_req), .av_rsp(av_rsp),
        .edge_pin(edge_pin), .irq(irq), .running(running), .underflow_pulse(underflow_pulse));
    task automatic stop_test();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    // Waitrequest is read before this edge's updates land, so the answer is taken at its own edge.
    task automatic bus(input logic wr, input logic [4:0] adr, input pit_byte_t wd);
        int n;
        n = 0;
        @(posedge clk);
        av_req.address <= adr;
        av_req.writedata <= {24'h000000, wd};
        av_req.byteenable <= 4'hF;
        av_req.write <= wr;
        av_req.read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (av_rsp.waitrequest !== 1'b0 && n < 50);
        rd = av_rsp.readdata[7:0];
        av_req.read <= 1'b0;
        av_req.write <= 1'b0;
        if (n >= 50) begin
            errors++;
            stop_test();
        end
    endtask : bus
    // Returns the edge count at which a pulse was seen, or 0 when none came.
    task automatic wait_undf(input int lim, input logic must, output int cyc);
        int n;
        n = 0;
        cyc = 0;
        do begin
            @(posedge clk);
            n++;
            if (underflow_pulse === 1'b1) begin
                cyc = n;
            end
        end while (cyc == 0 && n < lim);
        if (must && cyc == 0) begin
            errors++;
            stop_test();
        end
    endtask : wait_undf
    task automatic poll_run(input logic exp);
        int n;
        n = 0;
        do begin
            bus(1'b0, `PIT_OFS_CTRL, 8'h00);
            n++;
        end while (rd[1] !== exp && n < 10);
        check("running flag", rd[1], exp);
        if (rd[1] !== exp) begin
            stop_test();
        end
    endtask : poll_run
    task automatic t_reset();
        logic [4:0] adr[4] = '{`PIT_OFS_CTRL, `PIT_OFS_MODE, `PIT_OFS_IRQ, 5'h14};
        bus(1'b1, 5'h14, 8'hFF);
        foreach (adr[i]) begin
            bus(1'b0, adr[i], 8'h00);
            check("reset value", rd, 8'h00);
        end
        bus(1'b0, `PIT_OFS_PRE, 8'h00);
        check("reset prescaler", rd, `PIT_RST_RELOAD);
        bus(1'b0, `PIT_OFS_CNT, 8'h00);
        check("reset counter", rd, `PIT_RST_RELOAD);
    endtask : t_reset
    task automatic t_period();
        bus(1'b1, `PIT_OFS_IRQ, 8'h00);
        bus(1'b1, `PIT_OFS_CTRL, 8'h00);
        poll_run(1'b0);
        bus(1'b1, `PIT_OFS_PRE, 8'h01);
        bus(1'b1, `PIT_OFS_CNT, 8'h01);
        bus(1'b1, `PIT_OFS_MODE, 8'h10);
        bus(1'b0, `PIT_OFS_MODE, 8'h00);
        check("mode readback", rd, 8'h10);
        bus(1'b0, `PIT_OFS_CNT, 8'h00);
        check("counter load", rd, 8'h01);
        bus(1'b1, `PIT_OFS_IRQ, 8'h01);
        bus(1'b0, `PIT_OFS_IRQ, 8'h00);
        check("level set", rd, 8'h01);
        bus(1'b1, `PIT_OFS_CTRL, 8'h01);
        poll_run(1'b1);
        wait_undf(200, 1'b1, c);
        wait_undf(200, 1'b1, c);
        check("period", 32'(c), 32'(PERIOD));
        bus(1'b0, `PIT_OFS_CTRL, 8'h00);
        check("ctrl after underflow", rd, 8'h23);
        bus(1'b0, `PIT_OFS_IRQ, 8'h00);
        check("irq ctrl", rd, 8'h09);
        check("irq pin", irq, 1'b1);
        bus(1'b1, `PIT_OFS_CTRL, 8'h00);
        poll_run(1'b0);
        check("flags cleared", rd, 8'h00);
        bus(1'b1, `PIT_OFS_IRQ, 8'h01);
        bus(1'b0, `PIT_OFS_IRQ, 8'h00);
        check("request cleared", rd, 8'h01);
        check("irq pin low", irq, 1'b0);
    endtask : t_period
    task automatic t_level0();
        bus(1'b1, `PIT_OFS_IRQ, 8'h00);
        bus(1'b1, `PIT_OFS_CTRL, 8'h01);
        wait_undf(200, 1'b1, c);
        repeat (3) @(posedge clk);
        check("irq at level zero", irq, 1'b0);
        bus(1'b0, `PIT_OFS_IRQ, 8'h00);
        check("request without level", rd, 8'h08);
        bus(1'b1, `PIT_OFS_CTRL, 8'h05);
        bus(1'b0, `PIT_OFS_CTRL, 8'h00);
        check("ctrl after forced stop", rd, 8'h00);
        check("running after forced stop", running, 1'b0);
        wait_undf(80, 1'b0, c);
        check("no count after stop", 32'(c), 32'd0);
        bus(1'b1, `PIT_OFS_IRQ, 8'h00);
    endtask : t_level0
    task automatic t_gate();
        pit_byte_t md[3] = '{8'h90, 8'h11, 8'h20};
        foreach (md[i]) begin
            bus(1'b1, `PIT_OFS_MODE, md[i]);
            bus(1'b1, `PIT_OFS_CTRL, 8'h01);
            wait_undf(80, 1'b0, c);
            check("blocked source", 32'(c), 32'd0);
            bus(1'b1, `PIT_OFS_CTRL, 8'h00);
        end
        bus(1'b1, `PIT_OFS_MODE, 8'h10);
    endtask : t_gate
    // The pin passes a synchroniser, so it is held for several cycles.
    task automatic t_edge();
        @(posedge clk);
        edge_pin <= 1'b1;
        repeat (5) @(posedge clk);
        edge_pin <= 1'b0;
        bus(1'b0, `PIT_OFS_CTRL, 8'h00);
        check("edge flag set", rd, 8'h10);
        bus(1'b1, `PIT_OFS_CTRL, 8'h00);
        bus(1'b0, `PIT_OFS_CTRL, 8'h00);
        check("edge flag cleared", rd, 8'h00);
    endtask : t_edge
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_period();
        t_level0();
        t_gate();
        t_edge();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
